// ===== rtl/fau_map.svh
// Offsets, field positions, reset values and timing counts for fault annunciation
`ifndef FAU_MAP_SVH
`define FAU_MAP_SVH
`define FAU_OFF_CTRL      4'h0
`define FAU_OFF_STATUS    4'h1
`define FAU_OFF_ALARM     4'h2
`define FAU_OFF_UPG       4'h3
`define FAU_OFF_PWD       4'h4
`define FAU_OFF_FANDEV    4'h5
`define FAU_OFF_ADDR      4'h6
`define FAU_CTRL_CLR      0
`define FAU_CTRL_OUTOFF   1
`define FAU_CTRL_ADDROK   2
`define FAU_UPG_ENTER     8'h01
`define FAU_UPG_ERASE     8'h02
`define FAU_UPG_DONE      8'h03
`define FAU_UPG_EXIT      8'h04
`define FAU_PWD_CMD       8'he0
`define FAU_PWD_WORD      32'h55504744
`define FAU_CLK_MHZ       200
`define FAU_QTR_MS        250
`define FAU_QTR_CYC       (`FAU_QTR_MS * 1000 * `FAU_CLK_MHZ)
`define FAU_HOTPLUG_S     15
`define FAU_HOTPLUG_CYC   (`FAU_HOTPLUG_S * 32'd1000000 * `FAU_CLK_MHZ)
`define FAU_FAN_PCT       20
`define FAU_RST_STATUS    8'h00
`define FAU_RST_ALARM     8'h00
`endif

// ===== rtl/fau_pkg.sv
// Types shared by the fault annunciation block
package fau_pkg;
	typedef enum logic [1:0] {
		FAU_UP_IDLE  = 2'b00,
		FAU_UP_BOOT  = 2'b01,
		FAU_UP_BUSY  = 2'b10,
		FAU_UP_FAIL  = 2'b11
	} fau_upg_type;

	typedef struct packed {
		logic       in_present;   // Some input power remains
		logic       in_ok;        // Input within limits
		logic       ext_fault;    // Overload or input out of limits
		logic       int_fault;    // Fault inside the supply
		logic       out_present;  // Output voltage present
		logic [7:0] info_alarm;   // Information-only alarms
	} fau_cond_type;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [31:0] wdata;
	} fau_bus_type;
endpackage : fau_pkg

// ===== rtl/fau_annunciator.sv
// Fault annunciation, alert generation, LED patterns and upgrade gating
// Behaviour
// RULE_01: External faults never light fault LED, fault pin or bus alert.
// RULE_02: Input LED blinks while input out of range and power remains; off when lost. Code blinks it only with no internal fault and no upgrade.
// RULE_03: Power-up raises an event notice to the host.
// RULE_04: Hot insertion raises an event notice to the host.
// RULE_05: Any status or alarm bit pattern change asserts the bus alert.
// RULE_06: Host-commanded status changes update status without raising alert.
// RULE_07: After hot insertion, answer at default address low bits zero for fifteen seconds.
// RULE_08: Host pauses communication fifteen seconds after seeing a new module.
// RULE_09: Fan speeds differing over twenty percent give a wear-out warning only.
// RULE_10: Information-only alarms are reported without causing shutdown.
// RULE_11: Input LED green whenever input within normal limits.
// RULE_12: Output LED green ok, blinks on fault with output, red when shut down.
// RULE_13: During upgrade fault LED shows off, wink, fast blink or steady on.
// RULE_14: Wink is quarter second on, three quarters off.
// RULE_15: Fast blink is quarter second on, quarter second off.
// RULE_16: Boot loader switches output off before reprogramming continues.
// RULE_17: Validated upgrade lets application run; failure stays in boot loader.
// RULE_18: Upgrade commands locked until password command with unlock word.
// RULE_19: Alert on final state; contents frozen until clear, additions allowed.
// RULE_20: Faults sticky, reassert after clear; operational states not sticky.
// RULE_21: Blink counter from device clock restarts phase when display changes.
`include "fau_map.svh"
`timescale 1ns/10ps
module fau_annunciator
	import fau_pkg::*;
#(
	parameter int unsigned QTR_CYC     = `FAU_QTR_CYC,     // Quarter second in cycles
	parameter int unsigned HOTPLUG_CYC = `FAU_HOTPLUG_CYC  // Address settle time
) (
	input  wire logic         core_clk,      // 200 MHz clock
	input  wire logic         rstn,          // Async reset, active low
	input  wire fau_bus_type  bus,           // Register bus request
	output logic [31:0]       rdata,         // Read data, cycle after read
	input  wire fau_cond_type cond,          // Live supply conditions
	input  wire logic         hot_inserted,  // Pulse: module inserted live
	input  wire logic         final_state,   // Transients have settled
	input  wire logic         app_valid,     // Uploaded image validated
	input  wire logic         erase_fail,    // Erase or program failed
	input  wire logic [7:0]   fan_a,         // Fan A speed
	input  wire logic [7:0]   fan_b,         // Fan B speed
	input  wire logic [2:0]   addr_strap,    // Backplane address bits
	output logic              alert_n,       // Bus alert, active low
	output logic              fault_pin,     // Fault output pin
	output logic              output_en,     // Main output enable
	output logic              input_good_led,     // Input LED green
	output logic              output_fault_led_g, // Output LED green
	output logic              output_fault_led_r, // Output LED red
	output logic [2:0]        bus_addr_lo    // Low bus address bits
);
	localparam int unsigned HOLD_W = $clog2(HOTPLUG_CYC + 1);
	localparam int unsigned PH_W   = $clog2(4 * QTR_CYC + 1);

	function automatic logic fan_skew(input logic [7:0] a, input logic [7:0] b);
		logic [15:0] hi;
		logic [15:0] lo;
		hi = (a > b) ? {8'h00, a} : {8'h00, b};
		lo = (a > b) ? {8'h00, b} : {8'h00, a};
		fan_skew = (16'(hi * 16'd100) > 16'(lo * 16'(100 + `FAU_FAN_PCT)));
	endfunction : fan_skew

	// Status and alarm registers
	logic [7:0]  status_ff, nxt_status;
	logic [7:0]  alarm_ff, nxt_alarm;
	logic [7:0]  seen_st_ff, nxt_seen_st;
	logic [7:0]  seen_al_ff, nxt_seen_al;
	logic        event_ff, nxt_event;
	logic        frozen_ff, nxt_frozen;
	logic        pwrup_ff, nxt_pwrup;
	logic        outoff_ff, nxt_outoff;
	logic        unlock_ff, nxt_unlock;
	fau_upg_type upg_ff, nxt_upg;
	logic [HOLD_W-1:0] hold_ff, nxt_hold;
	logic [31:0] rdata_ff, nxt_rdata;
	logic        clr_req;
	logic        host_chg;
	logic [7:0]  live_status;
	logic [7:0]  live_alarm;

	assign clr_req = bus.wr && bus.addr == `FAU_OFF_CTRL && bus.wdata[`FAU_CTRL_CLR];

	always_comb begin
		// Internal faults only; external faults stay off the fault path
		// Commanded off shows at once, so the host write itself is not a change
		live_status = {4'h0, cond.out_present, nxt_outoff, cond.in_ok, cond.int_fault}; // RULE_01
		live_alarm  = cond.info_alarm | {7'h00, fan_skew(fan_a, fan_b)}; // RULE_09 RULE_10
	end

	always_comb begin
		nxt_status  = status_ff;
		nxt_alarm   = alarm_ff;
		nxt_seen_st = seen_st_ff;
		nxt_seen_al = seen_al_ff;
		nxt_event   = event_ff;
		nxt_frozen  = frozen_ff;
		nxt_pwrup   = 1'b0;
		nxt_outoff  = outoff_ff;
		nxt_unlock  = unlock_ff;
		nxt_hold    = hold_ff;
		host_chg    = 1'b0;
		if (bus.wr && bus.addr == `FAU_OFF_CTRL) begin
			nxt_outoff = bus.wdata[`FAU_CTRL_OUTOFF];
			host_chg   = 1'b1; // RULE_06
		end
		if (upg_ff != FAU_UP_IDLE)
			nxt_outoff = 1'b1; // RULE_16
		if (clr_req) begin
			// Sticky fault reasserts from live view; operational bits follow live
			nxt_status = live_status; // RULE_20
			nxt_alarm  = live_alarm;
			// Persisting internal fault raises the alert again at once
			nxt_frozen = live_status[0];
			nxt_event  = live_status[0]; // RULE_20
		end else if (!frozen_ff) begin
			nxt_status = live_status;
			nxt_alarm  = live_alarm;
		end else begin
			nxt_status = status_ff | (live_status & 8'h01); // RULE_19 RULE_20
			nxt_alarm  = alarm_ff | live_alarm; // RULE_19
			nxt_status[3:1] = live_status[3:1];
		end
		nxt_seen_st = host_chg ? nxt_status : seen_st_ff;
		nxt_seen_al = host_chg ? nxt_alarm : seen_al_ff; // RULE_06
		if (final_state && (nxt_status != seen_st_ff || nxt_alarm != seen_al_ff) && !host_chg) begin
			nxt_event   = 1'b1; // RULE_05
			nxt_frozen  = 1'b1; // RULE_19
			nxt_seen_st = nxt_status;
			nxt_seen_al = nxt_alarm;
		end
		if (pwrup_ff || hot_inserted)
			nxt_event = 1'b1; // RULE_03 RULE_04
		if (hot_inserted)
			nxt_hold = HOLD_W'(HOTPLUG_CYC); // RULE_07
		else if (hold_ff != '0)
			nxt_hold = hold_ff - 1'b1;
		if (bus.wr && bus.addr == `FAU_OFF_PWD)
			nxt_unlock = (bus.wdata == `FAU_PWD_WORD); // RULE_18
	end

	// Upgrade state, only reachable once unlocked
	always_comb begin
		nxt_upg = upg_ff;
		if (bus.wr && bus.addr == `FAU_OFF_UPG && unlock_ff) begin // RULE_18
			unique case (bus.wdata[7:0])
				`FAU_UPG_ENTER: nxt_upg = FAU_UP_BOOT;
				`FAU_UPG_ERASE: nxt_upg = FAU_UP_BUSY;
				`FAU_UPG_DONE:  nxt_upg = app_valid ? FAU_UP_BOOT : FAU_UP_FAIL; // RULE_17
				`FAU_UPG_EXIT:  nxt_upg = app_valid ? FAU_UP_IDLE : upg_ff; // RULE_17
				default:        nxt_upg = upg_ff;
			endcase
		end
		if (erase_fail && upg_ff == FAU_UP_BUSY)
			nxt_upg = FAU_UP_FAIL;
	end

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (bus.rd) begin
			unique case (bus.addr)
				`FAU_OFF_CTRL:   nxt_rdata = {29'h0, hold_ff == '0, outoff_ff, 1'b0};
				`FAU_OFF_STATUS: nxt_rdata = {24'h0, status_ff};
				`FAU_OFF_ALARM:  nxt_rdata = {24'h0, alarm_ff};
				`FAU_OFF_UPG:    nxt_rdata = {29'h0, unlock_ff, upg_ff};
				`FAU_OFF_ADDR:   nxt_rdata = {29'h0, bus_addr_lo};
				default:         nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			status_ff  <= `FAU_RST_STATUS;
			alarm_ff   <= `FAU_RST_ALARM;
			seen_st_ff <= `FAU_RST_STATUS;
			seen_al_ff <= `FAU_RST_ALARM;
			event_ff   <= 1'b0;
			frozen_ff  <= 1'b0;
			pwrup_ff   <= 1'b1;
			outoff_ff  <= 1'b0;
			unlock_ff  <= 1'b0;
			upg_ff     <= FAU_UP_IDLE;
			hold_ff    <= '0;
			rdata_ff   <= 32'h0000_0000;
		end else begin
			status_ff  <= nxt_status;
			alarm_ff   <= nxt_alarm;
			seen_st_ff <= nxt_seen_st;
			seen_al_ff <= nxt_seen_al;
			event_ff   <= nxt_event;
			frozen_ff  <= nxt_frozen;
			pwrup_ff   <= nxt_pwrup;
			outoff_ff  <= nxt_outoff;
			unlock_ff  <= nxt_unlock;
			upg_ff     <= nxt_upg;
			hold_ff    <= nxt_hold;
			rdata_ff   <= nxt_rdata;
		end
	end

	// LED pattern generator; phase restarts on any change of displayed mode
	logic [2:0]      mode_ff, nxt_mode;
	logic [PH_W-1:0] ph_ff, nxt_ph;
	logic            wink_on, fast_on;

	always_comb begin
		if (upg_ff != FAU_UP_IDLE)
			nxt_mode = {1'b1, upg_ff};
		else if (cond.int_fault)
			nxt_mode = cond.out_present ? 3'h1 : 3'h2;
		else if (!cond.in_ok && cond.in_present)
			nxt_mode = 3'h3;
		else
			nxt_mode = 3'h0;
		if (nxt_mode != mode_ff || ph_ff == PH_W'(4 * QTR_CYC - 1))
			nxt_ph = '0; // RULE_21
		else
			nxt_ph = ph_ff + 1'b1;
		wink_on = ph_ff < PH_W'(QTR_CYC); // RULE_14
		fast_on = (ph_ff < PH_W'(QTR_CYC)) || (ph_ff >= PH_W'(2 * QTR_CYC) &&
			ph_ff < PH_W'(3 * QTR_CYC)); // RULE_15
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mode_ff <= 3'h0;
			ph_ff   <= '0;
		end else begin
			mode_ff <= nxt_mode;
			ph_ff   <= nxt_ph;
		end
	end

	always_comb begin
		output_en          = !outoff_ff && !(status_ff[0] && !cond.out_present);
		alert_n            = !event_ff; // RULE_05
		fault_pin          = cond.int_fault; // RULE_01
		bus_addr_lo        = (hold_ff != '0) ? 3'h0 : addr_strap; // RULE_07
		rdata              = rdata_ff;
		input_good_led     = cond.in_ok ? 1'b1 :
			(cond.in_present && mode_ff == 3'h3 && fast_on); // RULE_02 RULE_11
		output_fault_led_g = 1'b0;
		output_fault_led_r = 1'b0;
		unique case (mode_ff)
			3'h1:    output_fault_led_g = fast_on; // RULE_12
			3'h2:    output_fault_led_r = 1'b1; // RULE_12
			3'h5:    output_fault_led_r = wink_on; // RULE_13
			3'h6:    output_fault_led_r = fast_on; // RULE_13
			3'h7:    output_fault_led_r = 1'b1; // RULE_13
			default: output_fault_led_g = cond.out_present && mode_ff != 3'h4;
		endcase
	end

	wink_shape_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_14
		(mode_ff == 3'h5 && ph_ff == PH_W'(QTR_CYC)) |-> !output_fault_led_r)
		else $error("wink on phase too long");
	fast_shape_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_15
		(mode_ff == 3'h6 && ph_ff == PH_W'(2 * QTR_CYC)) |-> output_fault_led_r)
		else $error("fast blink second pulse missing");
	ext_quiet_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_01
		(cond.ext_fault && !cond.int_fault && !frozen_ff) |-> !fault_pin ##1 !status_ff[0])
		else $error("external fault shown as internal");
	alert_change_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_05
		(final_state && !frozen_ff && !bus.wr && live_alarm != seen_al_ff) |=> !alert_n)
		else $error("alarm change without alert");
	hotplug_alert_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_04 RULE_07
		hot_inserted |=> !alert_n && bus_addr_lo == 3'h0)
		else $error("hot insert not announced");
	lock_upg_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_18
		(!unlock_ff && upg_ff == FAU_UP_IDLE && !erase_fail) |=> upg_ff == FAU_UP_IDLE)
		else $error("upgrade moved while locked");
	upg_outoff_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_16
		(upg_ff != FAU_UP_IDLE) |=> !output_en)
		else $error("output left on during upgrade");
	red_shut_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_12
		(mode_ff == 3'h2) |-> output_fault_led_r && !output_fault_led_g)
		else $error("shutdown not shown red");
	pwrup_alert_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_03
		$rose(rstn) ##0 pwrup_ff |=> !alert_n)
		else $error("power up not announced");
	sticky_fault_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_20
		(clr_req && cond.int_fault) |=> !alert_n)
		else $error("persisting fault not reasserted");
	final_wait_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_19
		(!final_state && !event_ff && !pwrup_ff && !hot_inserted && !clr_req) |=> alert_n)
		else $error("alert before final state");
	input_led_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_11
		cond.in_ok |-> input_good_led)
		else $error("input led dark with good input");
	info_noshut_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_10
		(cond.info_alarm != 8'h00 && cond.out_present && !outoff_ff) |-> output_en)
		else $error("information alarm shut output");
	upg_fail_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_17
		(upg_ff == FAU_UP_FAIL && !(bus.wr && bus.addr == `FAU_OFF_UPG))
		|=> upg_ff == FAU_UP_FAIL)
		else $error("failed upgrade left boot loader");

	wink_seen_c:  cover property (@(posedge core_clk) disable iff (!rstn) mode_ff == 3'h5);
	fail_seen_c:  cover property (@(posedge core_clk) disable iff (!rstn) mode_ff == 3'h7);
	clear_seen_c: cover property (@(posedge core_clk) disable iff (!rstn) clr_req && frozen_ff);
	blink_in_c:   cover property (@(posedge core_clk) disable iff (!rstn) mode_ff == 3'h3);
	reassert_c:   cover property (@(posedge core_clk) disable iff (!rstn) clr_req && cond.int_fault);
endmodule : fau_annunciator

// ===== bench/fau_host.sv
// System controller model: master of the register port
`include "fau_map.svh"
`timescale 1ns/10ps
module fau_host
	import fau_pkg::*;
#(
	parameter int unsigned HOLD_CYC = 20  // Quiet time after a new module
) (
	input  wire logic  core_clk,  // Device clock
	output fau_bus_type bus       // Request to the device
);
	logic [63:0] expq[$];  // {mask, expected} per read
	initial bus = '0;
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge core_clk);
		bus.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge core_clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~bus.wdata};
		expq.push_back({m, e});
		@(posedge core_clk);
		bus.rd <= 1'b0;
	endtask : rd
	task automatic hold_off();
		repeat (HOLD_CYC) @(posedge core_clk);
	endtask : hold_off
	task automatic unlock();
		wr(`FAU_OFF_PWD, `FAU_PWD_WORD);
	endtask : unlock
	task automatic go_offline();
		wr(`FAU_OFF_CTRL, 32'h2);
	endtask : go_offline
endmodule : fau_host

// ===== bench/fau_annunciator_tb.sv
// Self-checking bench for the fault annunciation block
`include "fau_map.svh"
`timescale 1ns/10ps
module fault_annunciation_and_upgrade_status_test;
	import fau_pkg::*;
	localparam int HOLD = 20;
	logic         core_clk, rstn, hot_inserted, final_state, app_valid, erase_fail;
	fau_bus_type  bus;
	fau_cond_type cond;
	logic [31:0]  rdata, seed;
	logic [7:0]   fan_a, fan_b;
	logic [2:0]   addr_strap, bus_addr_lo, strap;
	logic         alert_n, fault_pin, output_en, input_good_led, led_g, led_r, rd_seen;
	logic [63:0]  note;
	int           errors, total_checks, cycles;

	fau_host #(.HOLD_CYC(HOLD)) host (.core_clk(core_clk), .bus(bus));
	fau_annunciator #(.QTR_CYC(8), .HOTPLUG_CYC(HOLD)) dut (.core_clk(core_clk),
		.rstn(rstn), .bus(bus), .rdata(rdata), .cond(cond), .hot_inserted(hot_inserted),
		.final_state(final_state), .app_valid(app_valid), .erase_fail(erase_fail),
		.fan_a(fan_a), .fan_b(fan_b), .addr_strap(addr_strap), .alert_n(alert_n),
		.fault_pin(fault_pin), .output_en(output_en), .input_good_led(input_good_led),
		.output_fault_led_g(led_g), .output_fault_led_r(led_r), .bus_addr_lo(bus_addr_lo));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1) begin
			errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic complete_run();
		if (errors == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : complete_run
	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask : cyc
	// Counts lit cycles over 64, a whole number of every pattern period
	task automatic count_hi(input bit red, input int lo, input int hi);
		int c;
		c = 0;
		repeat (64) begin
			cyc(1);
			c += red ? led_r : input_good_led;
		end
		chk(c >= lo && c <= hi, "led pattern");
	endtask : count_hi
	task automatic clr();
		cyc(3);
		host.wr(`FAU_OFF_CTRL, 32'h1);
		cyc(3);
		chk(alert_n === 1'b1, "alert not cleared");
	endtask : clr
	task automatic upg(input logic [7:0] c);
		host.wr(`FAU_OFF_UPG, {24'h0, c});
		cyc(2);
	endtask : upg

	always @(posedge core_clk) begin
		if (rd_seen === 1'b1) begin
			note = host.expq.pop_front();
			chk((rdata & note[63:32]) === note[31:0], "read data");
		end
		rd_seen <= bus.rd;
		cycles <= cycles + 1;
		if (cycles > 8000) begin
			errors++;
			complete_run();
		end
	end

	initial begin
		seed = 32'h6713ccb4;
		{rstn, hot_inserted, erase_fail} = 3'h0;
		{final_state, app_valid} = 2'h3;
		cond = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 8'h00};
		{fan_a, fan_b, addr_strap} = {8'h64, 8'h64, 3'h0};
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		cyc(3);
		chk(alert_n === 1'b0, "no power-up alert");
		clr();
		chk(input_good_led === 1'b1 && led_g === 1'b1 && led_r === 1'b0, "leds");
		host.rd(4'h7, 32'h0, '1);
		@(posedge core_clk);
		cond.ext_fault <= 1'b1;
		repeat (10) begin
			cyc(1);
			chk(fault_pin === 1'b0 && alert_n === 1'b1, "external fault shown");
		end
		@(posedge core_clk);
		cond.ext_fault <= 1'b0;
		final_state <= 1'b0;
		seed = xs(seed);
		cond.info_alarm <= seed[7:0] | 8'h01;
		cyc(3);
		chk(alert_n === 1'b1, "alert before final state");
		@(posedge core_clk);
		final_state <= 1'b1;
		cyc(3);
		chk(alert_n === 1'b0 && output_en === 1'b1, "info alarm");
		@(posedge core_clk);
		cond.info_alarm <= 8'h00;
		clr();
		@(posedge core_clk);
		fan_b <= 8'h32;
		cyc(3);
		chk(alert_n === 1'b0 && output_en === 1'b1, "fan skew");
		@(posedge core_clk);
		fan_b <= 8'h64;
		clr();
		host.go_offline();
		cyc(3);
		chk(alert_n === 1'b1 && output_en === 1'b0, "host off");
		host.wr(`FAU_OFF_CTRL, 32'h0);
		@(posedge core_clk);
		cond.int_fault <= 1'b1;
		cond.out_present <= 1'b0;
		cyc(3);
		chk(fault_pin === 1'b1 && alert_n === 1'b0, "internal fault");
		chk(led_r === 1'b1 && led_g === 1'b0, "shutdown led");
		host.wr(`FAU_OFF_CTRL, 32'h1);
		cyc(3);
		chk(alert_n === 1'b0, "fault not sticky");
		@(posedge core_clk);
		{cond.int_fault, cond.out_present} <= 2'b01;
		clr();
		@(posedge core_clk);
		cond.in_ok <= 1'b0;
		count_hi(1'b0, 1, 63);
		@(posedge core_clk);
		cond.in_present <= 1'b0;
		count_hi(1'b0, 0, 0);
		@(posedge core_clk);
		{cond.in_present, cond.in_ok} <= 2'b11;
		clr();
		seed = xs(seed);
		strap = seed[2:0] | 3'h1;
		@(posedge core_clk);
		{addr_strap, hot_inserted} <= {strap, 1'b1};
		@(posedge core_clk);
		hot_inserted <= 1'b0;
		cyc(3);
		chk(alert_n === 1'b0 && bus_addr_lo === 3'h0, "hot insertion");
		host.hold_off();
		cyc(3);
		chk(bus_addr_lo === strap, "address not settled");
		clr();
		upg(`FAU_UPG_ENTER);
		host.rd(`FAU_OFF_UPG, 32'h0, 32'h7);
		host.unlock();
		upg(`FAU_UPG_ENTER);
		host.rd(`FAU_OFF_UPG, 32'h5, 32'h7);
		chk(output_en === 1'b0, "output on in boot");
		count_hi(1'b1, 16, 16);
		upg(`FAU_UPG_ERASE);
		count_hi(1'b1, 32, 32);
		@(posedge core_clk);
		erase_fail <= 1'b1;
		cyc(2);
		count_hi(1'b1, 64, 64);
		@(posedge core_clk);
		erase_fail <= 1'b0;
		upg(`FAU_UPG_ERASE);
		@(posedge core_clk);
		app_valid <= 1'b0;
		upg(`FAU_UPG_DONE);
		upg(`FAU_UPG_EXIT);
		host.rd(`FAU_OFF_UPG, 32'h7, 32'h7);
		app_valid <= 1'b1;
		upg(`FAU_UPG_ERASE);
		upg(`FAU_UPG_DONE);
		upg(`FAU_UPG_EXIT);
		host.rd(`FAU_OFF_UPG, 32'h0, 32'h3);
		count_hi(1'b1, 0, 0);
		complete_run();
	end
endmodule : fault_annunciation_and_upgrade_status_test
